// [hdl/smal_defines.vh]
/*
 static mac lookup: field positions, codes, sizes and reset values.
 assumes inclusion by both design files.
*/
`ifndef SMAL_DEFINES_VH
`define SMAL_DEFINES_VH
`define SMAL_ENTRIES 32
`define SMAL_IDX_W 5
`define SMAL_ENTRY_W 64
`define SMAL_MAC_LSB 0
`define SMAL_MAC_MSB 47
`define SMAL_PORTS_LSB 48
`define SMAL_PORTS_MSB 52
`define SMAL_VALID_BIT 53
`define SMAL_OVR_BIT 54
`define SMAL_RD_USE_BIT 56
`define SMAL_RD_FG_LSB 57
`define SMAL_RD_FG_MSB 63
`define SMAL_WR_USE_BIT 55
`define SMAL_WR_FG_LSB 56
`define SMAL_WR_FG_MSB 62
`define SMAL_SEL_RD 8'h10
`define SMAL_SEL_WR 8'h00
`define SMAL_PORTS_RESERVED 5'h01
`define SMAL_PORTS_ALL 5'h1f
`define SMAL_ENTRY_RESET 64'h0000000000000000
`endif

// [hdl/smal_store.v]
/*
 smal_store: 32 x 64 static entry memory, registered read data.
 assumes one writer, the indirect access path of the top.
*/
`timescale 1ns/1ps
`include "smal_defines.vh"
module smal_store (
   input wire clk,
   input wire we,
   input wire [4:0] waddr,
   input wire [63:0] wdata,
   input wire [4:0] raddr,
   output reg [63:0] rdata
);
   reg [63:0] mem [0:`SMAL_ENTRIES-1];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // smal_store

// [hdl/smal_lookup.v]
/*
 smal_lookup: static mac address table with indirect access and
 destination lookup merged with the dynamic table answer.
 assumes a register front end decodes spi writes into the indirect
 data image, selection code and trigger strobe; dynamic table and
 forwarding logic outside supply and take the lookup signals.
*/
// Function
// - destination lookup searches static and dynamic tables
// - source lookup uses dynamic table only
// - static destination match beats dynamic match
// - static store reachable only through spi path
// - static entries never age out
// - 32 entries, documented read image layout
// - write image uses its own packing
// - filter group joins match when flag set
// - override forwards despite spanning tree disable
// - entries without valid flag count as absent
// - port map one bit per port, ones broadcast
`timescale 1ns/1ps
`include "smal_defines.vh"
module smal_lookup (
   input wire clk,
   input wire resetn,
   input wire [63:0] ind_wdata,
   input wire [7:0] ind_select,
   input wire ind_trigger,
   input wire [4:0] ind_index,
   output reg [63:0] ind_rdata,
   output reg ind_rvalid,
   output reg ind_busy,
   input wire lu_req,
   input wire lu_is_da,
   input wire [47:0] lu_mac,
   input wire [6:0] lu_filter_group_id,
   input wire [4:0] lu_ingress_map,
   input wire [4:0] lu_stp_ok_map,
   input wire dyn_hit,
   input wire [4:0] dyn_ports,
   input wire [4:0] flood_ports,
   output reg res_valid,
   output reg res_static_hit,
   output reg res_override,
   output reg [4:0] res_ports
);
   localparam ST_IDLE = 4'b0001;
   localparam ST_WAIT = 4'b0010;
   localparam ST_SCAN = 4'b0100;
   localparam ST_DONE = 4'b1000;

   reg [3:0] state;
   reg [3:0] next_state;
   reg [4:0] scan_idx;
   reg rd_pending;
   reg scan_hit;
   reg [4:0] hit_ports;
   reg hit_ovr;
   reg [47:0] q_mac;
   reg [6:0] q_fg;
   reg q_da;
   reg [4:0] q_ing;
   reg [4:0] q_stp;
   reg q_dyn_hit;
   reg [4:0] q_dyn_ports;
   reg [4:0] q_flood;
   wire [63:0] mem_rdata;
   wire mem_we;
   wire [63:0] mem_wdata;
   wire [4:0] mem_raddr;

   // write image to stored (read) packing
   function [63:0] pack_write;
      input [63:0] w;
      begin
         pack_write = `SMAL_ENTRY_RESET;
         pack_write[`SMAL_RD_FG_MSB:`SMAL_RD_FG_LSB] = w[`SMAL_WR_FG_MSB:`SMAL_WR_FG_LSB];
         pack_write[`SMAL_RD_USE_BIT] = w[`SMAL_WR_USE_BIT];
         pack_write[`SMAL_OVR_BIT] = w[`SMAL_OVR_BIT];
         pack_write[`SMAL_VALID_BIT] = w[`SMAL_VALID_BIT];
         pack_write[`SMAL_PORTS_MSB:`SMAL_PORTS_LSB] = w[`SMAL_PORTS_MSB:`SMAL_PORTS_LSB];
         pack_write[`SMAL_MAC_MSB:`SMAL_MAC_LSB] = w[`SMAL_MAC_MSB:`SMAL_MAC_LSB];
      end
   endfunction

   // entry match against address and optional filter group
   function entry_match;
      input [63:0] e;
      input [47:0] mac;
      input [6:0] fg;
      begin
         entry_match = e[`SMAL_VALID_BIT] &&
            (e[`SMAL_MAC_MSB:`SMAL_MAC_LSB] == mac) &&
            (!e[`SMAL_RD_USE_BIT] || (e[`SMAL_RD_FG_MSB:`SMAL_RD_FG_LSB] == fg));
      end
   endfunction

   // manager access has priority in idle; a lookup does not start while any trigger is high
   assign mem_we = ind_trigger && (ind_select == `SMAL_SEL_WR);
   assign mem_wdata = pack_write(ind_wdata);
   assign mem_raddr = (state == ST_IDLE) ? ind_index : scan_idx;

   smal_store u_store (
      .clk(clk),
      .we(mem_we),
      .waddr(ind_index),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (lu_req && !ind_trigger) begin
               next_state = lu_is_da ? ST_WAIT : ST_DONE;
            end
         end
         ST_WAIT: begin
            next_state = ST_SCAN;
         end
         ST_SCAN: begin
            // data lag one index: wrap to zero means entry 31 is on the bus
            if (scan_idx == 5'h00) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // scan is 32 reads: slow but a single memory port, no cam
   always @(posedge clk) begin
      if (!resetn) begin
         state <= ST_IDLE;
         scan_idx <= 5'h00;
         scan_hit <= 1'b0;
         hit_ports <= 5'h00;
         hit_ovr <= 1'b0;
         q_mac <= 48'h000000000000;
         q_fg <= 7'h00;
         q_da <= 1'b0;
         q_ing <= 5'h00;
         q_stp <= 5'h00;
         q_dyn_hit <= 1'b0;
         q_dyn_ports <= 5'h00;
         q_flood <= 5'h00;
         res_valid <= 1'b0;
         res_static_hit <= 1'b0;
         res_override <= 1'b0;
         res_ports <= 5'h00;
      end else begin
         state <= next_state;
         res_valid <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (lu_req && !ind_trigger) begin
                  q_mac <= lu_mac;
                  q_fg <= lu_filter_group_id;
                  q_da <= lu_is_da;
                  q_ing <= lu_ingress_map;
                  q_stp <= lu_stp_ok_map;
                  q_dyn_hit <= dyn_hit;
                  q_dyn_ports <= dyn_ports;
                  q_flood <= flood_ports;
                  scan_idx <= 5'h00;
                  scan_hit <= 1'b0;
               end
            end
            ST_WAIT: begin
               scan_idx <= 5'h01;
            end
            ST_SCAN: begin
               // first valid match in index order wins
               if (!scan_hit && entry_match(mem_rdata, q_mac, q_fg)) begin
                  scan_hit <= 1'b1;
                  hit_ports <= mem_rdata[`SMAL_PORTS_MSB:`SMAL_PORTS_LSB];
                  hit_ovr <= mem_rdata[`SMAL_OVR_BIT];
               end
               scan_idx <= scan_idx + 5'h01;
            end
            ST_DONE: begin
               res_valid <= 1'b1;
               if (q_da && scan_hit) begin
                  res_static_hit <= 1'b1;
                  res_override <= hit_ovr;
                  // reserved bit 0 dropped, ingress excluded
                  res_ports <= hit_ports & ~`SMAL_PORTS_RESERVED & ~q_ing &
                     (hit_ovr ? `SMAL_PORTS_ALL : q_stp);
               end else begin
                  res_static_hit <= 1'b0;
                  res_override <= 1'b0;
                  res_ports <= (q_dyn_hit ? q_dyn_ports : q_flood) & ~`SMAL_PORTS_RESERVED & ~q_ing &
                     q_stp;
               end
            end
            default: begin
               scan_idx <= 5'h00;
            end
         endcase
      end
   end

   // wait cycle addresses entry 0, so the scan sees all 32 entries
   // indirect read path, valid one cycle after the store's registered data
   always @(posedge clk) begin
      if (!resetn) begin
         rd_pending <= 1'b0;
         ind_rdata <= `SMAL_ENTRY_RESET;
         ind_rvalid <= 1'b0;
         ind_busy <= 1'b0;
      end else begin
         rd_pending <= ind_trigger && (ind_select == `SMAL_SEL_RD) && (state == ST_IDLE);
         ind_rvalid <= rd_pending;
         ind_busy <= (next_state != ST_IDLE);
         if (rd_pending) begin
            // stored packing is the read image, bit 55 reads zero
            ind_rdata <= mem_rdata;
         end
      end
   end
   // no aging path exists: only mem_we writes the store
endmodule // smal_lookup

// [testbench/smal_chk_checker.sv]
/* smal_chk: port-level assertions for smal_lookup.
 assumes the bind below and a single clock domain. */
`timescale 1ns/1ps
module smal_chk (
   input wire clk,
   input wire resetn,
   input wire [7:0] ind_select,
   input wire ind_trigger,
   input wire [63:0] ind_rdata,
   input wire ind_rvalid,
   input wire ind_busy,
   input wire lu_req,
   input wire lu_is_da,
   input wire res_valid,
   input wire [4:0] res_ports
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // a request only counts when idle and not pre-empted
   wire go = lu_req && !ind_busy && !ind_trigger;
   a_read_answer: assert property (ind_trigger && ind_select == 8'h10 && !ind_busy |-> ##2 ind_rvalid)
      else $error("read answer missing");
   a_rvalid_pulse: assert property (ind_rvalid |=> !ind_rvalid)
      else $error("read valid too long");
   a_read_reserved: assert property (ind_rvalid |-> !ind_rdata[55])
      else $error("reserved read bit set");
   a_da_answer: assert property (go && lu_is_da |-> ##35 res_valid)
      else $error("dest result late");
   a_da_busy: assert property (go && lu_is_da |=> ind_busy [*8])
      else $error("busy dropped in scan");
   a_sa_answer: assert property (go && !lu_is_da |-> ##2 res_valid)
      else $error("source result late");
   a_port_zero: assert property (res_valid |-> !res_ports[0])
      else $error("reserved port set");
   a_res_pulse: assert property ($rose(res_valid) |=> !res_valid)
      else $error("result valid too long");
endmodule // smal_chk
bind smal_lookup smal_chk u_chk (.clk(clk), .resetn(resetn), .ind_select(ind_select), .ind_trigger(ind_trigger),
   .ind_rdata(ind_rdata), .ind_rvalid(ind_rvalid), .ind_busy(ind_busy), .lu_req(lu_req), .lu_is_da(lu_is_da),
   .res_valid(res_valid), .res_ports(res_ports));

// [testbench/smal_mgr.sv]
/* smal_mgr: table manager model driving the indirect path.
 assumes the caller starts after reset. */
`timescale 1ns/1ps
module smal_mgr (
   input wire clk,
   input wire [63:0] ind_rdata,
   input wire ind_rvalid,
   output reg [63:0] ind_wdata,
   output reg [7:0] ind_select,
   output reg ind_trigger,
   output reg [4:0] ind_index
);
   initial begin
      ind_wdata = 64'h0;
      ind_select = 8'hff;
      ind_trigger = 1'b0;
      ind_index = 5'h0;
   end
   task put(input [4:0] i, input [63:0] w); begin
      @(posedge clk);
      ind_wdata <= w;
      ind_select <= 8'h00;
      ind_index <= i;
      ind_trigger <= 1'b1;
      @(posedge clk);
      ind_trigger <= 1'b0;
      ind_wdata <= ~w; // stale image must not be reused
   end endtask
   task get(input [4:0] i, output [63:0] r); integer k; begin
      @(posedge clk);
      ind_select <= 8'h10;
      ind_index <= i;
      ind_trigger <= 1'b1;
      @(posedge clk);
      ind_trigger <= 1'b0;
      #1 k = 0;
      while (ind_rvalid !== 1'b1 && k < 8) begin
         @(posedge clk);
         #1 k = k + 1;
      end
      r = ind_rdata;
   end endtask
endmodule // smal_mgr

// [testbench/smal_lookup_tb_top.sv]
/* smal_lookup_tb_top: self-checking bench for smal_lookup.
 assumes smal_mgr and the bound checker. */
`timescale 1ns/1ps
module smal_lookup_tb_top;
   reg clk = 1'b0;
   reg resetn = 1'b0;
   reg lu_req = 1'b0, lu_is_da = 1'b0, dyn_hit = 1'b0;
   reg [47:0] lu_mac = 48'h0;
   reg [6:0] lu_filter_group_id = 7'h0;
   reg [4:0] lu_stp_ok_map = 5'h0;
   wire [63:0] wd, rd;
   wire [7:0] sel;
   wire trg, rv, busy, res_valid, res_hit, res_ovr;
   wire [4:0] idx, res_ports;
   reg [63:0] r;
   integer n_mismatch = 0, tests_run = 0, i;
   always #12.5 clk = ~clk;
   smal_mgr mgr (.clk(clk), .ind_rdata(rd), .ind_rvalid(rv), .ind_wdata(wd), .ind_select(sel),
      .ind_trigger(trg), .ind_index(idx));
   smal_lookup dut (.clk(clk), .resetn(resetn), .ind_wdata(wd), .ind_select(sel), .ind_trigger(trg),
      .ind_index(idx), .ind_rdata(rd), .ind_rvalid(rv), .ind_busy(busy), .lu_req(lu_req), .lu_is_da(lu_is_da),
      .lu_mac(lu_mac), .lu_filter_group_id(lu_filter_group_id), .lu_ingress_map(5'h04),
      .lu_stp_ok_map(lu_stp_ok_map), .dyn_hit(dyn_hit), .dyn_ports(5'h08), .flood_ports(5'h16),
      .res_valid(res_valid), .res_static_hit(res_hit), .res_override(res_ovr), .res_ports(res_ports));
   task check(input [63:0] seen, input [63:0] exp); begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   end endtask
   task finish_test; begin
      if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   end endtask
   task lu(input da, input [47:0] m, input [6:0] fg, input [4:0] stp, input dh, input h, input o,
      input [4:0] e);
      integer k; begin
      @(posedge clk);
      lu_req <= 1'b1;
      lu_is_da <= da;
      lu_mac <= m;
      lu_filter_group_id <= fg;
      lu_stp_ok_map <= stp;
      dyn_hit <= dh;
      @(posedge clk);
      lu_req <= 1'b0;
      lu_mac <= ~m;
      #1 k = 0;
      while (res_valid !== 1'b1 && k < 40) begin
         @(posedge clk);
         #1 k = k + 1;
      end
      check({57'h0, res_hit, res_ovr, res_ports}, {57'h0, h, o, e});
   end endtask
   initial begin
      #(25 * 3000);
      n_mismatch = n_mismatch + 1;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      for (i = 0; i < 32; i = i + 1) mgr.put(i, 64'h0);
      mgr.put(0, {11'h001, 5'h18, 48'h0a0b0c0d0e05});
      mgr.put(31, {11'h001, 5'h06, 48'h0a0b0c0d0e04});
      mgr.put(3, {11'h001, 5'h12, 48'h0a0b0c0d0e01});
      mgr.put(5, {1'b0, 7'h05, 3'h7, 5'h1f, 48'h0a0b0c0d0e02});
      mgr.put(9, {11'h000, 5'h02, 48'h0a0b0c0d0e03});
      mgr.get(5, r);
      check(r, {7'h05, 4'hb, 5'h1f, 48'h0a0b0c0d0e02});
      mgr.get(3, r);
      check(r, {11'h001, 5'h12, 48'h0a0b0c0d0e01});
      lu(1, 48'h0a0b0c0d0e01, 7'h00, 5'h1f, 1, 1, 0, 5'h12);
      lu(1, 48'h0a0b0c0d0e01, 7'h00, 5'h1d, 1, 1, 0, 5'h10);
      lu(1, 48'h0a0b0c0d0e02, 7'h05, 5'h00, 1, 1, 1, 5'h1a);
      lu(1, 48'h0a0b0c0d0e02, 7'h06, 5'h1f, 0, 0, 0, 5'h12);
      lu(1, 48'h0a0b0c0d0e03, 7'h00, 5'h1f, 1, 0, 0, 5'h08);
      lu(0, 48'h0a0b0c0d0e01, 7'h00, 5'h1f, 1, 0, 0, 5'h08);
      lu(1, 48'h0a0b0c0d0e04, 7'h00, 5'h1f, 1, 1, 0, 5'h02);
      lu(1, 48'h0a0b0c0d0e05, 7'h00, 5'h1f, 0, 1, 0, 5'h18);
      finish_test;
   end
endmodule // smal_lookup_tb_top
